/* File: hdl/ssim_top.sv */
// switch input monitor with spi read-out, daisy chaining and change interrupt
`timescale 1ns/1ps

// What this block does
// - monitors NUM_IN switch inputs, sixteen by default; shift path matches that width
// - narrow build is identical with eight inputs and eight-bit capture and shift
// - interrupt asserts while interrupt enable is high and live inputs differ from the captured status register
// - interrupt pin is driven only while interrupt enable is high, else released
// - interrupt clears at chip select fall or when inputs again match the register
// - each chip select fall captures all inputs into the status register
// - serial logic reacts only while chip select is low
// - first rising serial clock edge in a frame loads the shift register
// - after that edge the msb is on serial out; later rises shift msb first
// - serial input is sampled on every falling serial clock edge
// - serial input is accepted only while chip select is low
// - serial out is released while chip select is high, driven once it falls
// - interrupt is active-low open-drain so several outputs form a wired-and
module ssim_top #(
    parameter int NUM_IN = ssim_pkg::SSIM_WIDE_WIDTH
) (
    input  wire logic              clock,
    input  wire logic              srst,
    input  wire logic [NUM_IN-1:0] switchIn,
    input  wire logic              intEnable,
    input  wire logic              chipSelectN,
    input  wire logic              serialClock,
    input  wire logic              serialIn,
    output logic                   serialOut,
    output logic                   serialOutOe,
    output logic                   intOut,
    output logic                   intOe
);
    import ssim_pkg::*;

    // ****************************************
    // state types
    // ****************************************
    typedef struct packed {
        logic              csPrev;
        logic [NUM_IN-1:0] status;
        logic              serialOe;
        logic              intDrive;
        logic              intLevel;
    } ssim_sys_t;

    typedef struct packed {
        ssim_link_state_t  state;
        logic [NUM_IN-1:0] shift;
    } ssim_link_t;

    typedef struct packed {
        logic sample;
    } ssim_sample_t;

    localparam ssim_sys_t SYS_RESET = '{
        csPrev:   SSIM_CS_IDLE,
        status:   '0,
        serialOe: SSIM_DRIVE_LOW,
        intDrive: SSIM_DRIVE_LOW,
        intLevel: SSIM_DRIVE_LOW
    };
    localparam ssim_link_t   LINK_RESET   = '{state: SSIM_LINK_LOAD, shift: '0};
    localparam ssim_sample_t SAMPLE_RESET = '{sample: SSIM_DRIVE_LOW};
    localparam logic [NUM_IN+1:0] SYNC_INIT = {{NUM_IN{SSIM_DRIVE_LOW}}, SSIM_ENABLE_RESET, SSIM_CS_IDLE};

    // ****************************************
    // pin synchronisers into the system clock
    // ****************************************
    logic [NUM_IN-1:0] inSync;
    logic              enSync;
    logic              csSync;

    ssim_sync2 #(
        .WIDTH (NUM_IN + 2),
        .INIT  (SYNC_INIT)
    ) u_pinSync (
        .clock (clock),
        .srst  (srst),
        .din   ({switchIn, intEnable, chipSelectN}),
        .dout  ({inSync, enSync, csSync})
    );

    // ****************************************
    // system clock: capture, interrupt, output enable
    // ****************************************
    ssim_sys_t sysQ;
    ssim_sys_t sysD;

    always_comb begin
        sysD        = sysQ;
        sysD.csPrev = csSync;
        if (sysQ.csPrev && !csSync) begin
            sysD.status = inSync;
        end
        // the status register changes only here, so serial clocking cannot disturb it
        sysD.serialOe = !csSync;
        // comparing against the new value lets the capture itself clear the flag
        sysD.intDrive = enSync && (inSync != sysD.status);
        sysD.intLevel = SSIM_DRIVE_LOW;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            sysQ <= SYS_RESET;
        end else begin
            sysQ <= sysD;
        end
    end

    assign serialOutOe = sysQ.serialOe;
    assign intOe       = sysQ.intDrive;
    assign intOut      = sysQ.intLevel;

    // ****************************************
    // link clock, falling edge: serial input sample
    // ****************************************
    // chip select high holds the link logic in reset, so a stopped clock
    // between frames leaves nothing half done
    ssim_sample_t sampleQ;
    ssim_sample_t sampleD;

    always_comb begin
        sampleD        = sampleQ;
        sampleD.sample = serialIn;
    end

    always_ff @(negedge serialClock or posedge chipSelectN) begin
        if (chipSelectN) begin
            sampleQ <= SAMPLE_RESET;
        end else begin
            sampleQ <= sampleD;
        end
    end

    // ****************************************
    // link clock, rising edge: load and shift
    // ****************************************
    // the status word is read across domains without a handshake: it is held
    // still from its capture to the next chip select fall, so the first rise
    // must come a few system clocks after chip select falls
    ssim_link_t linkQ;
    ssim_link_t linkD;

    always_comb begin
        linkD = linkQ;
        unique case (linkQ.state)
            SSIM_LINK_LOAD: begin
                linkD.shift = sysQ.status;
                linkD.state = SSIM_LINK_SHIFT;
            end
            SSIM_LINK_SHIFT: begin
                linkD.shift = {linkQ.shift[NUM_IN-2:0], sampleQ.sample};
            end
            // a corrupted code falls back to loading, the frame restarts cleanly
            default: begin
                linkD.state = SSIM_LINK_LOAD;
            end
        endcase
    end

    always_ff @(posedge serialClock or posedge chipSelectN) begin
        if (chipSelectN) begin
            linkQ <= LINK_RESET;
        end else begin
            linkQ <= linkD;
        end
    end

    assign serialOut = linkQ.shift[NUM_IN-1];

endmodule : ssim_top

/* File: inc/ssim_pkg.sv */
// shared constants and types of the spi switch input monitor
package ssim_pkg;

    // ****************************************
    // variant widths
    // ****************************************
    localparam int SSIM_WIDE_WIDTH   = 16;
    localparam int SSIM_NARROW_WIDTH = 8;

    // ****************************************
    // pin levels and reset values
    // ****************************************
    localparam logic SSIM_DRIVE_LOW    = 1'h0;
    localparam logic SSIM_CS_IDLE      = 1'h1;
    localparam logic SSIM_ENABLE_RESET = 1'h0;

    // ****************************************
    // link-side frame state
    // ****************************************
    typedef enum logic [1:0] {
        SSIM_LINK_LOAD  = 2'h1,
        SSIM_LINK_SHIFT = 2'h2
    } ssim_link_state_t;

endpackage : ssim_pkg

/* File: hdl/ssim_sync2.sv */
// two flip-flop synchroniser for a bundle of independent levels
`timescale 1ns/1ps
module ssim_sync2 #(
    parameter int                 WIDTH = 1,
    parameter logic [WIDTH-1:0]   INIT  = '0
) (
    input  wire logic             clock,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    import ssim_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } ssim_sync_t;

    ssim_sync_t syncQ;
    ssim_sync_t syncD;

    // first stage feeds only the second stage
    always_comb begin
        syncD        = syncQ;
        syncD.meta   = din;
        syncD.stable = syncQ.meta;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            syncQ <= '{meta: INIT, stable: INIT};
        end else begin
            syncQ <= syncD;
        end
    end

    assign dout = syncQ.stable;

endmodule : ssim_sync2

/* File: test/ssim_assertions.sv */
// port checker for the switch monitor
`timescale 1ns/1ps
module ssim_assertions #(
    parameter int NUM_IN = 16
) (
    input wire logic              clock,
    input wire logic              srst,
    input wire logic [NUM_IN-1:0] switchIn,
    input wire logic              intEnable,
    input wire logic              chipSelectN,
    input wire logic              serialClock,
    input wire logic              serialIn,
    input wire logic              serialOut,
    input wire logic              serialOutOe,
    input wire logic              intOut,
    input wire logic              intOe
);
    logic [NUM_IN-1:0] capQ;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    // assumes inputs held still around the select fall, as the capture lags it through the synchronisers
    always_ff @(posedge clock) begin
        if (srst)
            capQ <= '0;
        else if ($fell(chipSelectN))
            capQ <= switchIn;
    end
    oe_off_a: assert property (chipSelectN [*5] |-> !serialOutOe) else $error("out driven idle");
    oe_rise_a: assert property ($rose(serialOutOe) |-> !$past(chipSelectN, 2) && !$past(chipSelectN, 3))
        else $error("out on early");
    oe_fall_a: assert property ($fell(serialOutOe) |-> $past(chipSelectN, 2) && $past(chipSelectN, 3))
        else $error("out off early");
    int_gate_a: assert property (!intEnable [*5] |-> !intOe) else $error("irq not gated");
    int_match_a: assert property ((intEnable && $stable(switchIn) && $stable(chipSelectN)) [*6]
        |-> intOe == (switchIn != capQ)) else $error("irq level wrong");
    int_clear_a: assert property ($stable(switchIn) [*4] ##0 $fell(chipSelectN)
        ##1 ($stable(switchIn) && !chipSelectN) [*5] |-> !intOe) else $error("irq not cleared");
    od_low_a: assert property (intOut == 1'h0) else $error("irq drives high");
    sdo_idle_a: assert property (chipSelectN |-> !serialOut) else $error("shift not reset");
endmodule : ssim_assertions
bind ssim_top ssim_assertions #(.NUM_IN(NUM_IN)) chk_u (.clock, .srst, .switchIn, .intEnable,
    .chipSelectN, .serialClock, .serialIn, .serialOut, .serialOutOe, .intOut, .intOe);

/* File: test/ssim_spi_ctrl.sv */
// spi controller model for the link side
`timescale 1ns/1ps
module ssim_spi_ctrl (
    output logic      chipSelectN,
    output logic      serialClock,
    output logic      serialIn,
    input wire logic  serialOut
);
    initial begin
        chipSelectN = 1'h0;
        serialClock = 1'h0;
        serialIn = 1'h0;
        // a select rise at start puts the link logic into its reset state
        #1 chipSelectN = 1'h1;
    end
    // 32 ns link clock, still outside frames; select lead covers the 40 ns settle time
    // edges kept off the system clock's so neither side races the other
    task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
        rx = '0;
        #3 chipSelectN = 1'h0;
        #61.3;
        for (int i = n - 1; i >= 0; i--) begin
            serialClock = 1'h1;
            #8 rx[i] = serialOut;
            serialIn = tx[i];
            #8 serialClock = 1'h0;
            #16;
        end
        chipSelectN = 1'h1;
        serialIn = 1'h0;
    endtask : xfer
endmodule : ssim_spi_ctrl

/* File: test/tb.sv */
// self-checking bench for the switch monitor
`timescale 1ns/1ps
module tb;
    import ssim_pkg::*;
    localparam int N = SSIM_WIDE_WIDTH;
    localparam int M = SSIM_NARROW_WIDTH;
    logic         clock, srst, intEnable, chipSelectN, serialClock, serialIn;
    logic         serialOut, serialOutOe, intOut, intOe;
    logic         serialOutN, serialOutOeN, intOutN, intOeN, chainLine, sdoLine, intPin;
    logic [N-1:0] switchIn, statusExp;
    logic [M-1:0] switchNarrow, narrowExp;
    logic [15:0]  lfsrVal;
    logic [31:0]  rx;
    int           miscompares, samples_checked;
    // a released chain line falls to the input's pull-down; the read line has no pull
    assign chainLine = serialOutOeN ? serialOutN : 1'h0;
    assign sdoLine   = serialOutOe ? serialOut : ~serialOut;
    // both interrupt outputs share one wire and one pull-up
    assign intPin    = !((intOe && !intOut) || (intOeN && !intOutN));
    ssim_top #(.NUM_IN(N)) dut_u (.clock, .srst, .switchIn, .intEnable, .chipSelectN,
        .serialClock, .serialIn(chainLine), .serialOut, .serialOutOe, .intOut, .intOe);
    // narrow device sits first in the chain, its output feeds the wide one
    ssim_top #(.NUM_IN(M)) dut_n_u (.clock, .srst, .switchIn(switchNarrow), .intEnable,
        .chipSelectN, .serialClock, .serialIn, .serialOut(serialOutN),
        .serialOutOe(serialOutOeN), .intOut(intOutN), .intOe(intOeN));
    ssim_spi_ctrl ctrl_u (.chipSelectN, .serialClock, .serialIn, .serialOut(sdoLine));
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    initial begin
        clock = 1'h0;
        forever #4 clock = ~clock;
    end
    initial begin
        #100us;
        miscompares++;
        complete_run();
    end
    initial begin
        srst = 1'h1;
        switchIn = '0;
        intEnable = 1'h0;
        lfsrVal = 16'h0041;
        statusExp = '0;
        switchNarrow = '0;
        narrowExp = '0;
        repeat (5) @(posedge clock);
        srst <= 1'h0;
        for (int r = 0; r < 8; r++) begin
            lfsrVal = lfsr(lfsrVal);
            @(posedge clock);
            switchIn <= lfsrVal[N-1:0];
            switchNarrow <= lfsrVal[11:4];
            intEnable <= (r != 2);
            repeat (8) @(posedge clock);
            check(intOe, intEnable && (switchIn != statusExp));
            check(intOeN, intEnable && (switchNarrow != narrowExp));
            check(intPin, !(intEnable && ((switchIn != statusExp) || (switchNarrow != narrowExp))));
            statusExp = switchIn;
            narrowExp = switchNarrow;
            // wide word, then narrow word, then the controller's byte, msb first
            ctrl_u.xfer(N + M + 8, {~lfsrVal[7:0], 24'h00_0000}, rx);
            check(rx, {statusExp, narrowExp, ~lfsrVal[7:0]});
            repeat (8) @(posedge clock);
            check({intOe, intOeN, serialOutOe, serialOutOeN, intOut, intOutN}, 6'h00);
        end
        complete_run();
    end
endmodule : tb
